// ===== hw/ebms_defines.svh
// Constants for the external bus mode sequencer
`ifndef EBMS_DEFINES_SVH
`define EBMS_DEFINES_SVH

// System clock period in ns (10 MHz)
`define EBMS_CLK_PERIOD_NS 100

// Bus format codes, one 2-bit field per chip select
`define EBMS_FMT_PASS 2'h0
`define EBMS_FMT_THREE 2'h1
`define EBMS_FMT_FOUR 2'h2
`define EBMS_FMT_SPARE 2'h3

// Width of one format field and of one clocks-per-state field
`define EBMS_FMT_W 2
`define EBMS_CLK_W 4

// Clocks per state limits for each format
`define EBMS_THREE_MIN_CLOCKS 4'h1
`define EBMS_FOUR_MIN_CLOCKS 4'h2
`define EBMS_MAX_CLOCKS 4'hF

// Reset values of the per chip select configuration
`define EBMS_RST_FORMAT 2'h0
`define EBMS_RST_CLOCKS 4'h2
`define EBMS_RST_MUX 1'h0

`endif

// ===== hw/ebms_pkg.sv
// Types shared by the external bus mode sequencer files
package ebms_pkg;

   // Bus cycle states; ebms_wait is an inserted stall state
   typedef enum logic [2:0] {
      ebms_idle,
      ebms_t1,
      ebms_t2,
      ebms_wait,
      ebms_t3,
      ebms_t4
   } ebms_state_t;

   // Bus format field of one chip select
   typedef logic [1:0] ebms_format_t;

endpackage

// ===== hw/ebms_state_timer.sv
// Clock counter that times one bus state of programmable length
`timescale 1ns/10ps
module ebms_state_timer
   import ebms_pkg::*;
#(
   parameter int W = 4
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [W-1:0] length,
   output logic [W-1:0] count,
   output logic last
);

   // Final clock of the current state
   assign last = run && (count == length - W'(1));

   // Count restarts from zero at each state boundary
   always_ff @(posedge clk)
   begin
      if (!resetn || !run || last)
      begin
         count <= '0;
      end
      else
      begin
         count <= count + W'(1);
      end
   end

endmodule

// ===== hw/ebms_sequencer.sv
// Bus cycle sequencer for the three-state and four-state bus formats
//
// Summary of operation
// - Three-state cycles run T1, T2, T3, stalls.
// - Three-state T1 drives address and chip select.
// - Three-state T2 asserts strobe plus memory/io request.
// - Wait low before T2 end inserts stalls.
// - Three-state T3 holds signals; read captured ending.
// - Three-state states last 1 to 15 clocks.
// - Four-state may multiplex low address onto data.
// - Four-state cycles run T1 to T4, stalls.
// - Four-state T1: address, select, latch strobe pulse.
// - Separate-bus write drives data from T1.
// - Four-state T2 asserts strobe plus memory/io request.
// - Ready low before T3 stalls; T3 holds signals.
// - Four-state read captures at T4, drops strobe.
// - Four-state write drops strobe at T4, holds buses.
// - Four-state states last 2 to 15 clocks.
// - Format and clocks set per chip select.
`timescale 1ns/10ps
`include "ebms_defines.svh"
module ebms_sequencer
   import ebms_pkg::*;
#(
   parameter int CS_COUNT = 4,
   parameter int AW = 24,
   parameter int DW = 8
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic cfg_load,
   input wire logic [CS_COUNT*`EBMS_FMT_W-1:0] cfg_format,
   input wire logic [CS_COUNT*`EBMS_CLK_W-1:0] cfg_clocks,
   input wire logic [CS_COUNT-1:0] cfg_mux,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_io,
   input wire logic [$clog2(CS_COUNT)-1:0] req_cs,
   input wire logic [AW-1:0] req_addr,
   input wire logic [DW-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic rsp_bypass,
   output logic [DW-1:0] rsp_rdata,
   output logic [AW-1:0] addr_out,
   output logic [DW-1:0] data_out,
   output logic data_oe,
   input wire logic [DW-1:0] data_in,
   output logic [CS_COUNT-1:0] chip_select_n,
   output logic read_n,
   output logic write_n,
   output logic memory_request_n,
   output logic io_request_n,
   output logic addr_latch,
   input wire logic wait_n
);

   localparam int CW = `EBMS_CLK_W;
   localparam int SW = $clog2(CS_COUNT);

   // Clamp a programmed state length into the range of its format
   function automatic logic [CW-1:0] state_len(
      input ebms_format_t fmt,
      input logic [CW-1:0] clocks
   );
      logic [CW-1:0] len;
      len = clocks;
      if (fmt == `EBMS_FMT_FOUR && clocks < `EBMS_FOUR_MIN_CLOCKS)
      begin
         len = `EBMS_FOUR_MIN_CLOCKS;
      end
      else if (clocks < `EBMS_THREE_MIN_CLOCKS)
      begin
         len = `EBMS_THREE_MIN_CLOCKS;
      end
      return len;
   endfunction

   // True for the states in which the strobes are asserted
   function automatic logic strobe_state(input ebms_state_t st);
      return (st == ebms_t2) || (st == ebms_wait) || (st == ebms_t3);
   endfunction

   ebms_format_t fmt_cfg [CS_COUNT];
   logic [CW-1:0] clk_cfg [CS_COUNT];
   logic [CS_COUNT-1:0] mux_cfg;
   ebms_state_t state;
   ebms_state_t next_state;
   logic [SW-1:0] cs_q;
   logic write_q;
   logic io_q;
   logic four_q;
   logic mux_q;
   logic [CW-1:0] len_q;
   logic [AW-1:0] addr_q;
   logic [DW-1:0] wdata_q;
   logic wait_q;
   logic [CW-1:0] cnt;
   logic last;
   logic [CW-1:0] next_cnt;
   logic accept;
   logic req_pass;
   ebms_format_t req_fmt;
   logic sel_write;
   logic sel_io;
   logic sel_four;
   logic sel_mux;
   logic [SW-1:0] sel_cs;
   logic [CW-1:0] sel_len;
   logic [AW-1:0] sel_addr;
   logic [DW-1:0] sel_wdata;
   logic in_cycle;
   logic addr_phase;

   // Per chip select configuration, pass-through after reset
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < CS_COUNT; i++)
         begin
            fmt_cfg[i] <= `EBMS_RST_FORMAT;
            clk_cfg[i] <= `EBMS_RST_CLOCKS;
            mux_cfg[i] <= `EBMS_RST_MUX;
         end
      end
      else if (cfg_load)
      begin
         for (int i = 0; i < CS_COUNT; i++)
         begin
            fmt_cfg[i] <= cfg_format[i*`EBMS_FMT_W +: `EBMS_FMT_W];
            clk_cfg[i] <= cfg_clocks[i*CW +: CW];
            mux_cfg[i] <= cfg_mux[i];
         end
      end
   end

   // Request acceptance and format lookup for the addressed chip select
   assign req_fmt = fmt_cfg[req_cs];
   assign accept = req_valid && req_ready && (state == ebms_idle);
   assign req_pass = (req_fmt != `EBMS_FMT_THREE)
      && (req_fmt != `EBMS_FMT_FOUR);

   // Attributes of the cycle about to run, current or being accepted
   always_comb
   begin
      if (accept)
      begin
         sel_write = req_write;
         sel_io = req_io;
         sel_four = (req_fmt == `EBMS_FMT_FOUR);
         sel_mux = mux_cfg[req_cs];
         sel_cs = req_cs;
         sel_len = state_len(req_fmt, clk_cfg[req_cs]);
         sel_addr = req_addr;
         sel_wdata = req_wdata;
      end
      else
      begin
         sel_write = write_q;
         sel_io = io_q;
         sel_four = four_q;
         sel_mux = mux_q;
         sel_cs = cs_q;
         sel_len = len_q;
         sel_addr = addr_q;
         sel_wdata = wdata_q;
      end
   end

   // Latch the accepted request for the length of its bus cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cs_q <= '0;
         write_q <= 1'b0;
         io_q <= 1'b0;
         four_q <= 1'b0;
         mux_q <= 1'b0;
         len_q <= `EBMS_RST_CLOCKS;
         addr_q <= '0;
         wdata_q <= '0;
      end
      else if (accept && !req_pass)
      begin
         cs_q <= sel_cs;
         write_q <= sel_write;
         io_q <= sel_io;
         four_q <= sel_four;
         mux_q <= sel_mux;
         len_q <= sel_len;
         addr_q <= sel_addr;
         wdata_q <= sel_wdata;
      end
   end

   // Wait input registered once; a low seen here was low a clock earlier
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wait_q <= 1'b1;
      end
      else
      begin
         wait_q <= wait_n;
      end
   end

   // Times each state, stall states included, at the configured length
   ebms_state_timer #(
      .W(CW)
   ) u_timer (
      .clk(clk),
      .resetn(resetn),
      .run(state != ebms_idle),
      .length(len_q),
      .count(cnt),
      .last(last)
   );

   assign next_cnt = (state == ebms_idle || last) ? '0 : cnt + CW'(1);

   // State sequence of one bus cycle
   always_comb
   begin
      next_state = state;
      unique case (state)
         ebms_idle:
         begin
            if (accept && !req_pass)
            begin
               next_state = ebms_t1;
            end
         end
         ebms_t1:
         begin
            if (last)
            begin
               next_state = ebms_t2;
            end
         end
         ebms_t2, ebms_wait:
         begin
            if (last)
            begin
               // Stall while wait was low a clock before state end
               next_state = wait_q ? ebms_t3 : ebms_wait;
            end
         end
         ebms_t3:
         begin
            if (last)
            begin
               next_state = four_q ? ebms_t4 : ebms_idle;
            end
         end
         ebms_t4:
         begin
            if (last)
            begin
               next_state = ebms_idle;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state <= ebms_idle;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign in_cycle = (next_state != ebms_idle);
   assign addr_phase = sel_four && sel_mux && (next_state == ebms_t1);

   // Address bus, loaded as T1 begins and held through the cycle
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         addr_out <= '0;
      end
      else if (accept && !req_pass)
      begin
         addr_out <= sel_addr;
      end
   end

   // Chip select low for the whole cycle, released when it ends
   always_ff @(posedge clk)
   begin
      if (!resetn || !in_cycle)
      begin
         chip_select_n <= '1;
      end
      else
      begin
         chip_select_n <= ~(CS_COUNT'(1) << sel_cs);
      end
   end

   // Read and store strobes from T2 through T3, dropped at T4 or end
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         read_n <= 1'b1;
         write_n <= 1'b1;
      end
      else
      begin
         read_n <= !(strobe_state(next_state) && !sel_write);
         write_n <= !(strobe_state(next_state) && sel_write);
      end
   end

   // Memory or io request from T2 until the cycle completes
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         memory_request_n <= 1'b1;
         io_request_n <= 1'b1;
      end
      else
      begin
         memory_request_n <= !((strobe_state(next_state)
            || next_state == ebms_t4) && !sel_io);
         io_request_n <= !((strobe_state(next_state)
            || next_state == ebms_t4) && sel_io);
      end
   end

   // Address latch strobe high for the first half of four-state T1
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         addr_latch <= 1'b0;
      end
      else
      begin
         addr_latch <= sel_four && (next_state == ebms_t1)
            && (next_cnt < (sel_len >> 1));
      end
   end

   // Data bus: low address in multiplexed T1, else write data
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         data_oe <= 1'b0;
         data_out <= '0;
      end
      else
      begin
         data_oe <= in_cycle && (addr_phase || sel_write);
         data_out <= addr_phase ? sel_addr[DW-1:0] : sel_wdata;
      end
   end

   // Read data captured on the edge that ends T3
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rsp_rdata <= '0;
      end
      else if (state == ebms_t3 && last && !write_q)
      begin
         rsp_rdata <= data_in;
      end
   end

   // Completion pulse, bypass pulse and readiness toward the CPU side
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         rsp_valid <= 1'b0;
         rsp_bypass <= 1'b0;
         req_ready <= 1'b0;
      end
      else
      begin
         rsp_valid <= last && ((state == ebms_t3 && !four_q)
            || state == ebms_t4);
         rsp_bypass <= accept && req_pass;
         req_ready <= (next_state == ebms_idle);
      end
   end

endmodule

// ===== testbench/ebms_sequencer_assertions.sv
// Bus pin checker for the external bus sequencer
`timescale 1ns/10ps
module ebms_sequencer_assertions
#(
   parameter int CS_COUNT = 4,
   parameter int AW = 24
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic rsp_valid,
   input wire logic rsp_bypass,
   input wire logic [AW-1:0] addr_out,
   input wire logic data_oe,
   input wire logic [CS_COUNT-1:0] chip_select_n,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic memory_request_n,
   input wire logic io_request_n,
   input wire logic addr_latch
);
   // Any chip select active
   wire sel = ~&chip_select_n;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   strobe_sel_a: assert property (
      !(read_n && write_n) |-> sel && (memory_request_n ^ io_request_n))
      else $error("strobe without select");
   latch_t1_a: assert property (
      $rose(addr_latch) |-> $rose(sel) && read_n && write_n)
      else $error("latch not at cycle start");
   latch_drop_a: assert property (
      $rose(addr_latch) |-> ##[1:7] !addr_latch)
      else $error("latch held too long");
   addr_hold_a: assert property (
      sel && $past(sel) |-> $stable(addr_out))
      else $error("address moved in cycle");
   end_rel_a: assert property (
      rsp_valid |-> $past(sel) && !sel && read_n && write_n && !data_oe
      && memory_request_n && io_request_n)
      else $error("bus not released at end");
   read_float_a: assert property (
      !read_n |-> !data_oe)
      else $error("data driven in read");
   write_drv_a: assert property (
      !write_n |-> data_oe)
      else $error("write data not driven");
   bypass_quiet_a: assert property (
      rsp_bypass |-> !sel && !$past(sel))
      else $error("select on pass-through");
   // Main scenarios
   cover property ($rose(addr_latch));
   cover property (rsp_bypass);
   cover property ($fell(write_n));
endmodule

bind ebms_sequencer ebms_sequencer_assertions #(
   .CS_COUNT(CS_COUNT),
   .AW(AW)
) i_ebms_sequencer_assertions (.*);

// ===== testbench/ebms_periph.sv
// Model of a memory or peripheral on the bus pins
`timescale 1ns/10ps
module ebms_periph
(
   input wire logic clk,
   input wire logic [3:0] chip_select_n,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic addr_latch,
   input wire logic [23:0] addr_out,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   input wire logic [3:0] stall,
   output logic [7:0] data_in = 8'h00,
   output logic wait_n,
   output logic [7:0] wr_seen,
   output logic [8:0] lat_seen
);
   logic [3:0] cnt = 4'h0;
   // Wait held low from idle for stall clocks of the selected cycle
   assign wait_n = cnt == 4'h0;
   always @(posedge clk)
      cnt <= &chip_select_n ? stall : cnt - 4'(cnt != 4'h0);
   // Read data while strobed, a changing pattern otherwise
   always @(posedge clk)
      data_in <= read_n ? ~data_in : addr_out[7:0] ^ 8'h5A;
   // Records write data and what stood on the data pins at latch
   always @(posedge clk)
   begin
      if (!write_n && data_oe)
         wr_seen <= data_out;
      if (addr_latch)
         lat_seen <= {data_oe, data_out};
   end
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench of the external bus sequencer
`timescale 1ns/10ps
module tb_top;
   // Format, clocks, mux, write, io, expected select-low clocks
   typedef struct packed {
      logic [1:0] f;
      logic [3:0] n;
      logic m, w, io;
      logic [5:0] e;
   } ebms_row_t;
   ebms_row_t r;
   ebms_row_t rows [10] = '{15'h2203, 15'h20C3, 15'h3E6D, 15'h2486,
      15'h4408, 15'h44C8, 15'h4348, 15'h4188, 15'h5FFC, 15'h460C};
   logic clk = '0, resetn = '0, cfg_load = '0, req_valid = '0;
   logic req_write = '0, req_io = '0, req_ready, rsp_valid, rsp_bypass;
   logic read_n, write_n, memory_request_n, io_request_n, mq, iq;
   logic data_oe, addr_latch, wait_n;
   logic [1:0] req_cs = '0;
   logic [3:0] cfg_mux = '0, stall = '0, chip_select_n, sel;
   logic [7:0] cfg_format = '0, req_wdata = '0, rsp_rdata, data_out;
   logic [7:0] data_in, wr_seen, b, d;
   logic [8:0] lat_seen;
   logic [15:0] cfg_clocks = '0;
   logic [23:0] req_addr = '0, addr_out;
   int mismatches = 0, n_tests = 0, cyc = 0, lo = 0, k = 0;

   ebms_sequencer i_ebms_sequencer (.*);
   ebms_periph i_ebms_periph (.*);

   // Clock of 100 ns
   always #50 clk = ~clk;

   // Hang guard and bus observation
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         mismatches++;
         stop_test;
      end
      if (chip_select_n !== 4'hF)
         lo++;
      sel = sel & chip_select_n;
      mq = mq | !memory_request_n;
      iq = iq | !io_request_n;
   end

   // Prints counts and verdict, ends the run
   task automatic stop_test;
   begin
      $display("Compares %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask

   // Compares a seen value with the expected one
   task automatic chk(input logic [31:0] v, input logic [31:0] e);
   begin
      n_tests++;
      if (v !== e)
      begin
         mismatches++;
         $display("Error at %0t: got %0h, want %0h", $time, v, e);
      end
   end
   endtask

   // Loads format, clocks and mux of one chip select
   task automatic cfg(input logic [1:0] c, f, input logic [3:0] n,
      input logic m);
   begin
      cfg_format[c*2+:2] <= f;
      cfg_clocks[c*4+:4] <= n;
      cfg_mux[c] <= m;
      cfg_load <= 1'h1;
      @(posedge clk);
      cfg_load <= 1'h0;
   end
   endtask

   // Presents one request and counts clocks to its answer
   task automatic xfer(input logic [1:0] c, input logic w, o,
      input logic [23:0] a, input logic [7:0] v);
   begin
      lo = 0;
      k = 0;
      mq = '0;
      iq = '0;
      sel = 4'hF;
      req_cs <= c;
      req_write <= w;
      req_io <= o;
      req_addr <= a;
      req_wdata <= v;
      req_valid <= 1'h1;
      do
         @(posedge clk);
      while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (rsp_valid !== 1'h1 && rsp_bypass !== 1'h1 && k < 300);
   end
   endtask

   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      foreach (rows[i])
      begin
         r = rows[i];
         b = 8'h10 + 8'(i);
         d = 8'h30 + 8'(i);
         cfg(2'(i), r.f, r.n, r.m);
         xfer(2'(i), r.w, r.io, {16'hA5C3, b}, d);
         chk(k, 1 + r.e);
         chk(lo, r.e);
         chk(sel, 4'hF ^ (4'h1 << i % 4));
         chk({mq, iq}, {!r.io, r.io});
         chk(addr_out, {16'hA5C3, b});
         if (r.w)
            chk(wr_seen, d);
         else
            chk(rsp_rdata, b ^ 8'h5A);
         if (r.f == 2'h2 && (r.m || r.w))
            chk(lat_seen, {1'h1, r.m ? b : d});
         else if (r.f == 2'h2)
            chk(lat_seen[8], 1'h0);
         $display("Row %0d done", i);
      end
      // Far side stalls a three-state read, then a four-state write
      stall <= 4'h8;
      cfg(2'h0, 2'h1, 4'h2, 1'h0);
      xfer(2'h0, 1'h0, 1'h0, 24'h000077, 8'h00);
      chk(lo > 6 && lo % 2 == 0, 1'h1);
      chk(rsp_rdata, 8'h2D);
      stall <= 4'hC;
      cfg(2'h1, 2'h2, 4'h2, 1'h1);
      xfer(2'h1, 1'h1, 1'h1, 24'h000001, 8'hE7);
      chk(lo > 8 && lo % 2 == 0, 1'h1);
      chk(wr_seen, 8'hE7);
      stall <= 4'h0;
      $display("Stall test done");
      // Reset in mid-cycle, then the default format passes through
      req_valid <= 1'h1;
      repeat (3) @(posedge clk);
      resetn <= 1'h0;
      req_valid <= 1'h0;
      repeat (2) @(posedge clk);
      chk({chip_select_n, read_n, write_n}, 6'h3F);
      chk(req_ready, 1'h0);
      resetn <= 1'h1;
      xfer(2'h2, 1'h0, 1'h0, 24'h000005, 8'h00);
      chk(k + lo, 1);
      $display("Reset test done");
      stop_test;
   end
endmodule
